/* include/irq_vec_pkg.sv */
// Constants used by the interrupt prioritiser; its request latch uses none of them.
package irq_vec_pkg;
  localparam int unsigned NUM_LEVELS = 10;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_POWER_DOWN = 14'h002C;
  localparam logic [13:0] VEC_BASE = 14'h0004;
  localparam logic [13:0] VEC_STEP = 14'h0004;
  localparam logic [13:0] VEC_TIMER = 14'h0028;
  localparam logic [9:0] MASK_RESET = 10'h000;
  // Level index of each source, 0 is the highest maskable priority.
  localparam int unsigned LVL_SENSE = 0;
  localparam int unsigned LVL_LEVEL_ONE = 1;
  localparam int unsigned LVL_LEVEL_ZERO = 2;
  localparam int unsigned LVL_SP0_TX = 3;
  localparam int unsigned LVL_SP0_RX = 4;
  localparam int unsigned LVL_EDGE = 5;
  localparam int unsigned LVL_DMA = 6;
  localparam int unsigned LVL_SP1_TX = 7;
  localparam int unsigned LVL_SP1_RX = 8;
  localparam int unsigned LVL_TIMER = 9;
endpackage

/* rtl/irq_edge_latch.sv */
// Edge latch that holds one interrupt request until it is acknowledged.
`timescale 1ns/10ps
module irq_edge_latch (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic level_in,
  input  wire logic edge_mode,
  input  wire logic ack,
  output logic      request
);
  logic prev_q;
  logic prev_d;
  logic held_q;
  logic held_d;
  logic rise;

  assign rise = level_in & ~prev_q;

  always_comb begin
    prev_d = level_in;
    // A new edge in the acknowledge cycle wins so that it is not lost.
    held_d = rise ? 1'b1 : (ack ? 1'b0 : held_q);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      held_q <= held_d;
    end
  end

  assign request = edge_mode ? held_q : level_in;
endmodule

/* rtl/dsp_interrupt_vectoring.sv */
// Interrupt prioritiser and vector generator for one DSP processor.
// Contract
// - Fixed vectors: reset 0x0000, power down 0x002C, others 0x0004 up, timer 0x0028.
// - After reset all maskable interrupt servicing stays disabled until software unmasks.
// - The edge request pin latches on its rising edge, not level.
// - The selectable sense pin uses edge or level as software chooses.
// - Both level pins request for as long as they are held.
// - Shared pins serve as flag and request at the same time.
// - An unmasked pin vectors whether driven externally or as flag output.
// - Serial ports raise separate receive and transmit word interrupts.
// - In autobuffer mode the serial interrupt fires once per whole buffer.
// - Every level except power down and reset is individually maskable.
`timescale 1ns/10ps
module dsp_interrupt_vectoring (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  flag_pin_in,
  input  wire logic [3:0]  flag_out,
  input  wire logic [3:0]  flag_dir_out,
  output logic [3:0]       flag_pin_out,
  output logic [3:0]       flag_pin_oe,
  output logic [3:0]       flag_read,
  input  wire logic        alt_request_pin_one,
  input  wire logic        alt_request_pin_zero,
  input  wire logic        sp1_alt_irq_mode,
  input  wire logic        sense_edge_mode,
  input  wire logic        mask_wr,
  input  wire logic [9:0]  mask_wdata,
  output logic [9:0]       interrupt_mask_reg,
  input  wire logic        sp0_tx_word,
  input  wire logic        sp0_rx_word,
  input  wire logic        sp0_tx_buf_done,
  input  wire logic        sp0_rx_buf_done,
  input  wire logic        sp0_autobuf,
  input  wire logic        sp1_tx_word,
  input  wire logic        sp1_rx_word,
  input  wire logic        sp1_tx_buf_done,
  input  wire logic        sp1_rx_buf_done,
  input  wire logic        sp1_autobuf,
  input  wire logic        dma_done,
  input  wire logic        timer_expired,
  input  wire logic        power_down_req,
  input  wire logic        vector_ack,
  output logic             vector_valid,
  output logic [13:0]      vector_addr,
  output logic [9:0]       pending
);
  // Flag pins: bit 3 selectable sense, 2 level one, 1 level zero, 0 edge.
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] pin_level;
  logic [9:0] mask_q;
  logic [9:0] mask_d;
  logic [9:0] raw;
  logic [9:0] edge_sel;
  logic [9:0] req;
  logic [9:0] ack_vec;
  logic       pd_q;
  logic       pd_d;
  logic       boot_q;
  logic       boot_d;
  logic [9:0] grant;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= flag_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Own drive is seen directly so a software-set flag vectors without delay.
  assign pin_level = (flag_dir_out & flag_out) | (~flag_dir_out & sync2_q);
  assign flag_pin_out = flag_out;
  assign flag_pin_oe = flag_dir_out;
  assign flag_read = pin_level;

  function automatic logic sp_event(input logic autobuf, input logic word, input logic buf_done);
    sp_event = autobuf ? buf_done : word;
  endfunction

  always_comb begin
    raw = 10'h000;
    raw[irq_vec_pkg::LVL_SENSE] = pin_level[3];
    raw[irq_vec_pkg::LVL_LEVEL_ONE] = pin_level[2];
    raw[irq_vec_pkg::LVL_LEVEL_ZERO] = pin_level[1];
    raw[irq_vec_pkg::LVL_SP0_TX] = sp_event(sp0_autobuf, sp0_tx_word, sp0_tx_buf_done);
    raw[irq_vec_pkg::LVL_SP0_RX] = sp_event(sp0_autobuf, sp0_rx_word, sp0_rx_buf_done);
    raw[irq_vec_pkg::LVL_EDGE] = pin_level[0];
    raw[irq_vec_pkg::LVL_DMA] = dma_done;
    raw[irq_vec_pkg::LVL_SP1_TX] = sp1_alt_irq_mode ? alt_request_pin_one
                                 : sp_event(sp1_autobuf, sp1_tx_word, sp1_tx_buf_done);
    raw[irq_vec_pkg::LVL_SP1_RX] = sp1_alt_irq_mode ? alt_request_pin_zero
                                 : sp_event(sp1_autobuf, sp1_rx_word, sp1_rx_buf_done);
    raw[irq_vec_pkg::LVL_TIMER] = timer_expired;
    // Pulsed peripheral events are always latched; pins follow their sense.
    edge_sel = 10'h3F8 & ~10'h006;
    edge_sel[irq_vec_pkg::LVL_EDGE] = 1'b1;
    edge_sel[irq_vec_pkg::LVL_SENSE] = sense_edge_mode;
    edge_sel[irq_vec_pkg::LVL_LEVEL_ONE] = 1'b0;
    edge_sel[irq_vec_pkg::LVL_LEVEL_ZERO] = 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < irq_vec_pkg::NUM_LEVELS; gi++) begin : g_lat
      irq_edge_latch u_lat (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level_in (raw[gi]),
        .edge_mode(edge_sel[gi]),
        .ack      (ack_vec[gi]),
        .request  (req[gi])
      );
    end
  endgenerate

  always_comb begin
    mask_d = mask_wr ? mask_wdata : mask_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= irq_vec_pkg::MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign interrupt_mask_reg = mask_q;
  assign pending = req;

  // Power down stays pending until taken; set wins over the acknowledge.
  always_comb begin
    pd_d = power_down_req | (pd_q & ~(vector_ack & ~boot_q));
    boot_d = boot_q & ~vector_ack;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
      boot_q <= 1'b1;
    end else begin
      pd_q <= pd_d;
      boot_q <= boot_d;
    end
  end

  // Lowest index wins; the rest stay pending, edge-mode ones held in their latches.
  always_comb begin
    grant = 10'h000;
    for (int i = irq_vec_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (req[i] && mask_q[i]) begin
        grant = 10'h000;
        grant[i] = 1'b1;
      end
    end
  end

  always_comb begin
    vector_valid = boot_q | pd_q | (|grant);
    vector_addr = irq_vec_pkg::VEC_RESET;
    ack_vec = 10'h000;
    if (boot_q) begin
      vector_addr = irq_vec_pkg::VEC_RESET;
    end else if (pd_q) begin
      vector_addr = irq_vec_pkg::VEC_POWER_DOWN;
    end else begin
      for (int i = 0; i < irq_vec_pkg::NUM_LEVELS; i++) begin
        if (grant[i]) begin
          vector_addr = 14'(irq_vec_pkg::VEC_BASE + 14'(i) * irq_vec_pkg::VEC_STEP);
          ack_vec[i] = vector_ack;
        end
      end
    end
  end

  a_timer_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!boot_q && !pd_q && grant == 10'h200) |-> vector_addr == irq_vec_pkg::VEC_TIMER)
    else $error("timer vector wrong");
  a_mask_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
    (grant & ~mask_q) == 10'h000)
    else $error("masked level granted");
  a_reset_masked: assert property (@(posedge core_clk) $rose(rst_n) |-> mask_q == 10'h000)
    else $error("mask not cleared by reset");
  a_edge_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($rose(raw[irq_vec_pkg::LVL_EDGE]) ##1 !ack_vec[irq_vec_pkg::LVL_EDGE])
    |=> req[irq_vec_pkg::LVL_EDGE])
    else $error("edge request lost");
  a_level_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    req[irq_vec_pkg::LVL_LEVEL_ONE] == pin_level[2])
    else $error("level request not following pin");
  a_sense_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sense_edge_mode |-> req[irq_vec_pkg::LVL_SENSE] == pin_level[3])
    else $error("sense pin not level");
  a_flag_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
    (flag_dir_out[2] && flag_out[2] && mask_q[1] && !boot_q && !pd_q && !req[0]) |-> vector_valid)
    else $error("flag output did not vector");
  a_priority_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    grant[5] |-> (req[4:0] & mask_q[4:0]) == 5'h00)
    else $error("lower level beat a higher one");
  a_autobuf_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sp0_autobuf && !sp0_tx_buf_done) |-> !raw[irq_vec_pkg::LVL_SP0_TX])
    else $error("autobuffer word raised interrupt");
  a_sp_sep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!sp0_autobuf && sp0_rx_word) |-> raw[irq_vec_pkg::LVL_SP0_RX])
    else $error("receive word not raised");

  c_timer: cover property (@(posedge core_clk) disable iff (!rst_n) grant[9] && vector_ack);
  c_pd: cover property (@(posedge core_clk) disable iff (!rst_n) pd_q && !boot_q && vector_ack);
  c_two_pending: cover property (@(posedge core_clk) disable iff (!rst_n) $countones(req & mask_q) > 1);
endmodule

/* verification/ext_irq_source.sv */
// Model of the external devices that drive the shared request pins.
`timescale 1ns/10ps
module ext_irq_source (
  input  wire logic       core_clk,
  input  wire logic [3:0] req,
  input  wire logic [3:0] rel,
  output logic [3:0]      pin_drv
);
  logic [3:0] last_q = 4'h0;
  // A released line shows the inverse of its last level, so a stale value never passes for a drive.
  always_ff @(posedge core_clk) last_q <= (rel & last_q) | (~rel & req);
  assign pin_drv = (rel & ~last_q) | (~rel & req);
endmodule

/* verification/dsp_interrupt_vectoring_tb.sv */
// Self-checking bench for the interrupt prioritiser and vector generator.
`timescale 1ns/10ps
module dsp_interrupt_vectoring_tb;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic [3:0]  req = 0, rel = 0, fo = 0, fd = 0, drv, pin_out, pin_oe, fread;
  logic [12:0] ev = 0;
  logic        ab0 = 0, ab1 = 0, alt = 0, sedge = 0, mwr = 0, ack = 0, valid;
  logic [9:0]  mwd = 0, mask, pend;
  logic [13:0] addr;
  int          bad_count = 0, n_tests = 0;
  wire  [3:0]  pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  always #20 core_clk = ~core_clk;
  ext_irq_source src (.core_clk(core_clk), .req(req), .rel(rel), .pin_drv(drv));
  dsp_interrupt_vectoring dut (.core_clk(core_clk), .rst_n(rst_n), .flag_pin_in(pin_in),
    .flag_out(fo), .flag_dir_out(fd), .flag_pin_out(pin_out), .flag_pin_oe(pin_oe), .flag_read(fread),
    .alt_request_pin_one(ev[11]), .alt_request_pin_zero(ev[12]), .sp1_alt_irq_mode(alt),
    .sense_edge_mode(sedge), .mask_wr(mwr), .mask_wdata(mwd), .interrupt_mask_reg(mask),
    .sp0_tx_word(ev[0]), .sp0_rx_word(ev[1]), .sp0_tx_buf_done(ev[2]), .sp0_rx_buf_done(ev[3]),
    .sp0_autobuf(ab0), .sp1_tx_word(ev[4]), .sp1_rx_word(ev[5]), .sp1_tx_buf_done(ev[6]),
    .sp1_rx_buf_done(ev[7]), .sp1_autobuf(ab1), .dma_done(ev[8]), .timer_expired(ev[9]),
    .power_down_req(ev[10]), .vector_ack(ack), .vector_valid(valid), .vector_addr(addr), .pending(pend));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic take(input logic [13:0] a);
    chk(valid, 1'b1);
    chk(addr, a);
    ack = 1;
    tick();
    ack = 0;
    // One idle edge keeps a following take from raising ack in the same step.
    tick();
  endtask
  task automatic pulse(input logic [12:0] m);
    ev = m;
    tick();
    ev = 0;
    tick();
  endtask
  task automatic set_mask(input logic [9:0] m);
    mwd = m;
    mwr = 1;
    tick();
    mwr = 0;
    tick();
  endtask
  task automatic t_reset;
    chk(mask, 10'h000);
    take(14'h0000);
    chk(valid, 1'b0);
  endtask
  task automatic t_mask;
    pulse(13'h0300);
    chk(pend[6], 1'b1);
    chk(valid, 1'b0);
    set_mask(10'h040);
    chk(mask, 10'h040);
    take(14'h001C);
    chk(valid, 1'b0);
    chk(pend[9], 1'b1);
    set_mask(10'h3FF);
    take(14'h0028);
  endtask
  task automatic t_prio;
    pulse(13'h0701);
    take(14'h002C);
    take(14'h0010);
    take(14'h001C);
    take(14'h0028);
    chk(valid, 1'b0);
  endtask
  task automatic t_events;
    logic [12:0] fire [3] = '{13'h0733, 13'h07CC, 13'h1F0C};
    logic [13:0] va [13] = '{14'h0010, 14'h0014, 14'h0010, 14'h0014, 14'h0020, 14'h0024, 14'h0020,
                             14'h0024, 14'h001C, 14'h0028, 14'h002C, 14'h0020, 14'h0024};
    for (int p = 0; p < 3; p++) begin
      ab0 = p > 0;
      ab1 = p > 0;
      alt = p == 2;
      tick();
      for (int i = 0; i < 13; i++) begin
        pulse(13'h0001 << i);
        if (fire[p][i]) take(va[i]);
        else chk(valid, 1'b0);
      end
    end
  endtask
  task automatic t_pins;
    logic [13:0] pa [4] = '{14'h0018, 14'h000C, 14'h0008, 14'h0004};
    for (int k = 0; k < 5; k++) begin
      int   b;
      logic lvl;
      b = k > 3 ? 3 : k;
      lvl = (b == 1) || (b == 2) || (k == 4);
      sedge = k == 3;
      req[b] = 1;
      tick(3);
      chk(fread[b], 1'b1);
      take(pa[b]);
      chk(valid, lvl);
      req[b] = 0;
      tick(3);
      chk(valid, 1'b0);
    end
  endtask
  task automatic t_flag;
    rel[2] = 1;
    fd[2] = 1;
    fo[2] = 1;
    tick(3);
    chk(pin_oe[2], 1'b1);
    chk(pin_out[2], 1'b1);
    take(14'h0008);
    fo[2] = 0;
    tick(3);
    chk(valid, 1'b0);
    chk(fread[2], 1'b0);
    chk(pin_out[2], 1'b0);
  endtask
  task automatic t_mid_reset;
    pulse(13'h0200);
    chk(pend[9], 1'b1);
    rst_n = 0;
    tick(2);
    chk(pend[9], 1'b0);
    chk(valid, 1'b1);
    rst_n = 1;
    tick();
    chk(mask, 10'h000);
    take(14'h0000);
    pulse(13'h0200);
    chk(valid, 1'b0);
    chk(pend[9], 1'b1);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(12);
    rst_n = 1;
    tick();
    t_reset();
    t_mask();
    t_prio();
    t_events();
    t_pins();
    t_flag();
    t_mid_reset();
    end_of_test();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #200us;
    bad_count++;
    end_of_test();
  end
endmodule
